// ---- core/cksd_defs.svh ----
`ifndef CKSD_DEFS_SVH
`define CKSD_DEFS_SVH

// register indices; the byte address on the bus is four times the index
`define CKSD_IDX_PIN_MODE 16'hFF9F
`define CKSD_IDX_IOSC_MODE 16'hFFA0
`define CKSD_IDX_MOSC_CTRL 16'hFFA2
`define CKSD_IDX_CLK_STATUS 16'hFFA8
`define CKSD_IDX_CPU_DIV 16'hFFFB

// reset values
`define CKSD_RST_PIN_MODE 8'h00
`define CKSD_RST_CPU_DIV 8'h01
`define CKSD_RST_IOSC_CTRL 2'h0
`define CKSD_RST_MOSC_CTRL 8'h80

// field positions
`define CKSD_BIT_EXT_CLOCK_SELECT 7
`define CKSD_BIT_OSCILLATOR_SELECT 6
`define CKSD_BIT_HS_OSC_STABLE 7
`define CKSD_BIT_LOW_SPEED_OSC_STOP 1
`define CKSD_BIT_HS_INTERNAL_OSC_STOP 0
`define CKSD_BIT_HS_SYSTEM_CLOCK_STOP 7
`define CKSD_BIT_MAIN_CLOCK_STATUS 0
`define CKSD_BIT_HS_SYS_RUNNING 1
`define CKSD_BIT_MAIN_CLK_RUNNING 2

// writable bit masks; all other bits are fixed zero except the stability flag in bit 7 of the oscillator mode register
`define CKSD_MASK_PIN_MODE 8'hC0
`define CKSD_MASK_CPU_DIV 8'h07
`define CKSD_MASK_IOSC_MODE 8'h03
`define CKSD_MASK_MOSC_CTRL 8'h80

// timing
`define CKSD_CLK_PERIOD_NS 8
`define CKSD_IHS_SETTLE_NS 10000
`define CKSD_IHS_SETTLE_CYC ((`CKSD_IHS_SETTLE_NS + `CKSD_CLK_PERIOD_NS - 1) / `CKSD_CLK_PERIOD_NS)

`endif

// ---- core/cksd_pkg.sv ----
package cksd_pkg;

	typedef enum logic [1:0] {
		CKSD_PIN_PORT = 2'h0,
		CKSD_PIN_CRYSTAL = 2'h1,
		CKSD_PIN_PORT_ALT = 2'h2,
		CKSD_PIN_EXT_CLOCK = 2'h3
	} cksd_pin_mode_e;

	typedef enum logic [2:0] {
		CKSD_DIV_1 = 3'h0,
		CKSD_DIV_2 = 3'h1,
		CKSD_DIV_4 = 3'h2,
		CKSD_DIV_8 = 3'h3,
		CKSD_DIV_16 = 3'h4
	} cksd_div_e;

	typedef enum logic [1:0] {
		CKSD_OSC_OFF = 2'h0,
		CKSD_OSC_SETTLING = 2'h1,
		CKSD_OSC_STABLE = 2'h3
	} cksd_osc_state_e;

	typedef logic [7:0] cksd_byte_t;

endpackage

// ---- core/cksd_if.sv ----
interface cksd_if;
	logic [2:0] div_code;
	logic clk_run;
	logic cpu_tick;
	logic ihs_run;
	logic ihs_stable;

	modport ctrl (
		output div_code,
		output clk_run,
		output ihs_run,
		input cpu_tick,
		input ihs_stable
	);

	modport divider (
		input div_code,
		input clk_run,
		output cpu_tick
	);

	modport settle (
		input ihs_run,
		output ihs_stable
	);
endinterface

// ---- core/cksd_settle.sv ----
`include "cksd_defs.svh"

module cksd_settle (
	input wire logic clk_i,
	input wire logic rst_i,
	cksd_if.settle osc
);
	import cksd_pkg::*;

	localparam logic [10:0] SETTLE_LAST = 11'(`CKSD_IHS_SETTLE_CYC - 1);

	cksd_osc_state_e state_q, state_d;
	logic [10:0] cnt_q, cnt_d;
	logic cnt_done;

	assign cnt_done = (cnt_q == SETTLE_LAST);
	assign osc.ihs_stable = (state_q == CKSD_OSC_STABLE);

	// a stop throws away the settled state: a restart must settle again
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		unique case (state_q)
			CKSD_OSC_OFF: begin
				cnt_d = 11'h000;
				if (osc.ihs_run) begin
					state_d = CKSD_OSC_SETTLING;
				end
			end
			CKSD_OSC_SETTLING: begin
				cnt_d = cnt_q + 11'h001;
				if (!osc.ihs_run) begin
					state_d = CKSD_OSC_OFF;
				end else if (cnt_done) begin
					state_d = CKSD_OSC_STABLE;
				end
			end
			CKSD_OSC_STABLE: begin
				cnt_d = 11'h000;
				if (!osc.ihs_run) begin
					state_d = CKSD_OSC_OFF;
				end
			end
			default: begin
				state_d = CKSD_OSC_OFF;
				cnt_d = 11'h000;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= CKSD_OSC_OFF;
			cnt_q <= 11'h000;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end
endmodule // cksd_settle

// ---- core/cksd_divider.sv ----
module cksd_divider (
	input wire logic clk_i,
	input wire logic rst_i,
	cksd_if.divider div
);
	import cksd_pkg::*;

	logic [3:0] cnt_q;
	logic [3:0] mask;
	logic tick_q;
	logic at_end;

	// prohibited codes fall back to the slowest ratio rather than run too fast
	assign mask = (div.div_code == CKSD_DIV_1) ? 4'h0 :
		(div.div_code == CKSD_DIV_2) ? 4'h1 :
		(div.div_code == CKSD_DIV_4) ? 4'h3 :
		(div.div_code == CKSD_DIV_8) ? 4'h7 : 4'hF;
	assign at_end = ((cnt_q & mask) == mask);
	assign div.cpu_tick = tick_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 4'h0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= div.clk_run ? cnt_q + 4'h1 : 4'h0;
			tick_q <= div.clk_run && at_end;
		end
	end
endmodule // cksd_divider

// ---- core/cksd_top.sv ----
`include "cksd_defs.svh"

// Summary of operation
// R1 - pin mode 00/10 input port, 01 crystal oscillation, 11 external clock input.
// R2 - pin mode register resets to zero, both oscillator pins are input ports.
// R3 - software writes zero to the low six bits of the pin mode register.
// R4 - software changes pin mode bits only while the high-speed clock stop bit is 1.
// R5 - divider codes 000 to 100 give divide by 1, 2, 4, 8, 16; others prohibited.
// R6 - divider register resets to 01H, divide by two.
// R7 - the divider never slows the peripheral clock.
// R8 - software writes zero to bits three to seven of the divider register.
// R9 - internal oscillator register reads 00H after reset, then 80H once stable.
// R10 - stability flag reads 0 while settling and 1 once running stably.
// R11 - low-speed stop bit 1 stops the low-speed oscillator, 0 keeps it running.
// R12 - high-speed stop bit 1 stops the internal high-speed oscillator, 0 runs it.
// R13 - software stops the internal oscillator only while the high-speed system clock is used.
// R14 - main oscillator control register resets to 80H, high-speed system clock stopped.
// R15 - stop bit 0 runs crystal or enables external clock; 1 stops or disables it.
// R16 - software clears the high-speed stop bit only while the regulator register is 00H.
// R17 - software sets the high-speed stop bit only while the internal clock is used.
// R18 - software never clears the high-speed stop bit in input port mode.
// R19 - peripherals get no clock while stopped; software reinitializes them after restart.
// R20 - main clock status reads 0 on internal clock, 1 on high-speed system clock.
// R21 - fixed-zero register bits read zero whatever was written.
module cksd_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [17:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic main_clock_status_i,
	output cksd_pkg::cksd_pin_mode_e pin_mode_o,
	output logic crystal_pin_port_o,
	output logic x2_pin_port_o,
	output logic crystal_osc_en_o,
	output logic ext_clock_en_o,
	output logic hs_internal_osc_en_o,
	output logic low_speed_osc_en_o,
	output logic main_clk_running_o,
	output logic cpu_clk_tick_o,
	output logic periph_clk_en_o
);
	import cksd_pkg::*;

	cksd_if link ();

	// register state
	cksd_byte_t pin_mode_q;
	cksd_byte_t cpu_div_q;
	logic [1:0] iosc_ctrl_q;
	cksd_byte_t mosc_ctrl_q;

	// bus state
	logic ack_q;
	logic [31:0] rdata_q;
	logic err_q;

	// bus decode
	logic access;
	logic aligned;
	logic [15:0] idx;
	logic hit_pin_mode;
	logic hit_cpu_div;
	logic hit_iosc_mode;
	logic hit_mosc_ctrl;
	logic hit_status;
	logic hit_any;
	logic wr_commit;
	cksd_byte_t wbyte;
	cksd_byte_t rd_byte;

	// clock state
	logic ihs_stop;
	logic ils_stop;
	logic hs_sys_stop;
	cksd_pin_mode_e pin_mode;
	logic hs_sys_running;
	logic ihs_running;
	logic main_running;
	cksd_byte_t iosc_mode_rd;
	cksd_byte_t status_rd;

	// one wait state: the first access cycle loads the read data flop, the second ends the transfer
	assign access = psel_i && penable_i;
	assign aligned = (paddr_i[1:0] == 2'h0);
	assign idx = paddr_i[17:2];
	assign hit_pin_mode = aligned && (idx == `CKSD_IDX_PIN_MODE);
	assign hit_cpu_div = aligned && (idx == `CKSD_IDX_CPU_DIV);
	assign hit_iosc_mode = aligned && (idx == `CKSD_IDX_IOSC_MODE);
	assign hit_mosc_ctrl = aligned && (idx == `CKSD_IDX_MOSC_CTRL);
	assign hit_status = aligned && (idx == `CKSD_IDX_CLK_STATUS);
	assign hit_any = hit_pin_mode || hit_cpu_div || hit_iosc_mode || hit_mosc_ctrl || hit_status;
	assign wr_commit = access && ack_q && pwrite_i && hit_any;
	assign wbyte = pwdata_i[7:0];

	assign pready_o = ack_q;
	assign pslverr_o = err_q;
	assign prdata_o = rdata_q;

	// control bits out of the registers
	assign pin_mode = cksd_pin_mode_e'(pin_mode_q[`CKSD_BIT_EXT_CLOCK_SELECT -: 2]);
	assign ihs_stop = iosc_ctrl_q[`CKSD_BIT_HS_INTERNAL_OSC_STOP];
	assign ils_stop = iosc_ctrl_q[`CKSD_BIT_LOW_SPEED_OSC_STOP];
	assign hs_sys_stop = mosc_ctrl_q[`CKSD_BIT_HS_SYSTEM_CLOCK_STOP];

	// pin decode: both port codes leave the pins alone [R1]
	assign crystal_pin_port_o = (pin_mode != CKSD_PIN_CRYSTAL); // [R1]
	assign x2_pin_port_o = (pin_mode == CKSD_PIN_PORT) || (pin_mode == CKSD_PIN_PORT_ALT); // [R1]

	// stop bit gates whichever high-speed source the pin mode has chosen [R15]
	assign crystal_osc_en_o = (pin_mode == CKSD_PIN_CRYSTAL) && !hs_sys_stop; // [R15]
	assign ext_clock_en_o = (pin_mode == CKSD_PIN_EXT_CLOCK) && !hs_sys_stop; // [R15]
	assign hs_sys_running = crystal_osc_en_o || ext_clock_en_o;

	assign hs_internal_osc_en_o = !ihs_stop; // [R12]
	assign low_speed_osc_en_o = !ils_stop; // [R11]

	// the internal source counts as running only once it has settled
	assign ihs_running = link.ihs_stable;
	assign main_running = main_clock_status_i ? hs_sys_running : ihs_running; // [R20]
	assign main_clk_running_o = main_running;

	// peripheral clock follows the main clock undivided and stops with it [R7] [R19]
	assign periph_clk_en_o = main_running; // [R7] [R19]
	assign cpu_clk_tick_o = link.cpu_tick;

	assign link.div_code = cpu_div_q[2:0]; // [R5]
	assign link.clk_run = main_running;
	assign link.ihs_run = !ihs_stop; // [R12]

	// stability flag is zero until the settle timer finishes [R9] [R10]
	assign iosc_mode_rd = {link.ihs_stable, 5'h00, iosc_ctrl_q}; // [R9] [R10] [R21]
	assign status_rd = {5'h00, main_running, hs_sys_running, main_clock_status_i}; // [R20]

	assign rd_byte = hit_pin_mode ? pin_mode_q :
		hit_cpu_div ? cpu_div_q :
		hit_iosc_mode ? iosc_mode_rd :
		hit_mosc_ctrl ? mosc_ctrl_q :
		hit_status ? status_rd : 8'h00;

	cksd_settle u_settle (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.osc(link.settle)
	);

	cksd_divider u_divider (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.div(link.divider)
	);

	// bus handshake
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= access && !ack_q;
			err_q <= access && !ack_q && !hit_any;
			if (access && !ack_q) begin
				rdata_q <= (pwrite_i || !hit_any) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
			end
		end
	end

	// pin mode register; pin mode changes are trusted to come with the stop bit set [R4]
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_mode_q <= `CKSD_RST_PIN_MODE; // [R2]
		end else if (wr_commit && hit_pin_mode) begin
			pin_mode_q <= wbyte & `CKSD_MASK_PIN_MODE; // [R21] [R3]
		end
	end

	// divider register; a prohibited code is stored as written
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_div_q <= `CKSD_RST_CPU_DIV; // [R6]
		end else if (wr_commit && hit_cpu_div) begin
			cpu_div_q <= wbyte & `CKSD_MASK_CPU_DIV; // [R21] [R8]
		end
	end

	// internal oscillator stop bits; the stability flag is not writable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			iosc_ctrl_q <= `CKSD_RST_IOSC_CTRL; // [R9]
		end else if (wr_commit && hit_iosc_mode) begin
			iosc_ctrl_q <= 2'(wbyte & `CKSD_MASK_IOSC_MODE); // [R11] [R12] [R13]
		end
	end

	// main oscillator control; no lockout, software owns the sequencing [R16] [R17] [R18]
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mosc_ctrl_q <= `CKSD_RST_MOSC_CTRL; // [R14]
		end else if (wr_commit && hit_mosc_ctrl) begin
			mosc_ctrl_q <= wbyte & `CKSD_MASK_MOSC_CTRL; // [R21]
		end
	end

	assign pin_mode_o = pin_mode;
endmodule // cksd_top

// ---- tb/cksd_top_props.sv ----
module cksd_top_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input cksd_pkg::cksd_pin_mode_e pin_mode_o,
	input wire logic crystal_pin_port_o,
	input wire logic x2_pin_port_o,
	input wire logic crystal_osc_en_o,
	input wire logic ext_clock_en_o,
	input wire logic main_clk_running_o,
	input wire logic cpu_clk_tick_o,
	input wire logic periph_clk_en_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import cksd_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_setup; psel_i && !penable_i; endsequence
	sequence s_access; psel_i && penable_i; endsequence
	sequence s_halted; !main_clk_running_o [*2]; endsequence
	// exactly one wait state, so a master that waits longer still sees a clean answer
	AST_ONE_WAIT: assert property (s_setup ##1 s_access |-> !pready_o ##1 pready_o)
		else $error("pready not in second access cycle");
	AST_ERR_DATA: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
		else $error("error response without ready or with data");
	AST_DATA_HI: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
		else $error("upper read data not zero");
	AST_X1_PORT: assert property (crystal_pin_port_o == (pin_mode_o != CKSD_PIN_CRYSTAL))
		else $error("crystal pin port mode wrong");
	AST_X2_PORT: assert property (x2_pin_port_o == !pin_mode_o[0])
		else $error("second pin port mode wrong");
	AST_XTAL_EN: assert property (crystal_osc_en_o |-> pin_mode_o == CKSD_PIN_CRYSTAL)
		else $error("crystal enabled outside crystal mode");
	AST_EXT_EN: assert property (ext_clock_en_o |-> pin_mode_o == CKSD_PIN_EXT_CLOCK)
		else $error("external clock enabled outside its mode");
	AST_PERIPH: assert property (periph_clk_en_o == main_clk_running_o)
		else $error("peripheral clock not undivided main clock");
	AST_TICK_STOP: assert property (s_halted |=> !cpu_clk_tick_o)
		else $error("cpu tick while main clock stopped");
	AST_RST_STATE: assert property ($fell(rst_i) |-> pin_mode_o == CKSD_PIN_PORT && !pready_o)
		else $error("state after reset wrong");
endmodule // cksd_top_props
bind cksd_top cksd_top_props u_props (.clk_i, .rst_i, .psel_i, .penable_i, .prdata_o, .pready_o,
	.pslverr_o, .pin_mode_o, .crystal_pin_port_o, .x2_pin_port_o, .crystal_osc_en_o,
	.ext_clock_en_o, .main_clk_running_o, .cpu_clk_tick_o, .periph_clk_en_o);

// ---- tb/cksd_top_bench.sv ----
`include "cksd_defs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
	$display("unexpected at %0t: %0h vs %0h", $time, a, b); end end
module cksd_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import cksd_pkg::*;
	localparam logic [17:0] A_PIN = {`CKSD_IDX_PIN_MODE, 2'h0};
	localparam logic [17:0] A_OSC = {`CKSD_IDX_IOSC_MODE, 2'h0};
	localparam logic [17:0] A_MOC = {`CKSD_IDX_MOSC_CTRL, 2'h0};
	localparam logic [17:0] A_STS = {`CKSD_IDX_CLK_STATUS, 2'h0};
	localparam logic [17:0] A_DIV = {`CKSD_IDX_CPU_DIV, 2'h0};
	logic clk, rst, psel, penable, pwrite, pready, pslverr, main_clock_status, er;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	cksd_pin_mode_e pin_mode;
	logic x1_port, x2_port, xtal_en, ext_en, ihs_en, ls_en, main_run, tick, periph_en;
	int errors = 0;
	int check_count = 0;
	int n;
	cksd_top uut (.clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .main_clock_status_i(main_clock_status),
		.pin_mode_o(pin_mode), .crystal_pin_port_o(x1_port), .x2_pin_port_o(x2_port),
		.crystal_osc_en_o(xtal_en), .ext_clock_en_o(ext_en), .hs_internal_osc_en_o(ihs_en),
		.low_speed_osc_en_o(ls_en), .main_clk_running_o(main_run), .cpu_clk_tick_o(tick),
		.periph_clk_en_o(periph_en));
	always #4 clk = ~clk;
	task give_verdict;
		if (errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// request held until the pready edge, released after it, one idle edge before the next
	task apb(input logic [17:0] a, input logic w, input logic [7:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task rd_chk(input logic [17:0] a, input logic [31:0] e);
		apb(a, 1'b0, 8'h00);
		`CHK(rd, e)
	endtask
	// the first tick after a divider change may be short, so skip the first two ticks before counting
	task gap;
		for (int i = 0; i < 2; i++) begin
			do @(posedge clk); while (tick !== 1'b1);
		end
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (tick !== 1'b1 && n < 100);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		give_verdict();
	end
	initial begin
		clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; main_clock_status = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd_chk(A_PIN, 32'h00);
		rd_chk(A_DIV, 32'h01);
		rd_chk(A_OSC, 32'h00);
		rd_chk(A_MOC, 32'h80);
		`CHK(periph_en, 1'b0)
		repeat (1300) @(posedge clk);
		rd_chk(A_OSC, 32'h80);
		`CHK(periph_en, 1'b1)
		`CHK(main_run, 1'b1)
		rd_chk(A_STS, 32'h04);
		main_clock_status <= 1'b1;
		rd_chk(A_STS, 32'h01);
		`CHK(periph_en, 1'b0)
		main_clock_status <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			apb(A_PIN, 1'b1, {m[1:0], 6'h00});
			rd_chk(A_PIN, {24'h0, m[1:0], 6'h00});
			`CHK(pin_mode, m[1:0])
			`CHK(x1_port, m != 1)
			`CHK(x2_port, ~m[0])
		end
		apb(A_PIN, 1'b1, 8'hFF);
		rd_chk(A_PIN, 32'hC0);
		for (int m = 1; m < 4; m += 2) begin
			apb(A_PIN, 1'b1, {m[1:0], 6'h00});
			apb(A_MOC, 1'b1, 8'h00);
			`CHK(xtal_en, m == 1)
			`CHK(ext_en, m == 3)
			apb(A_MOC, 1'b1, 8'h80);
			`CHK({xtal_en, ext_en}, 2'b00)
		end
		for (int c = 0; c < 5; c++) begin
			apb(A_DIV, 1'b1, c[7:0]);
			gap();
			`CHK(n, 1 << c)
			`CHK(periph_en, 1'b1)
		end
		apb(A_DIV, 1'b1, 8'hFF);
		rd_chk(A_DIV, 32'h07);
		apb(A_OSC, 1'b1, 8'h02);
		`CHK(ls_en, 1'b0)
		rd_chk(A_OSC, 32'h82);
		main_clock_status <= 1'b1;
		apb(A_OSC, 1'b1, 8'h01);
		`CHK({ihs_en, ls_en}, 2'b01)
		rd_chk(A_OSC, 32'h01);
		apb(A_OSC, 1'b1, 8'h00);
		`CHK(ihs_en, 1'b1)
		main_clock_status <= 1'b0;
		repeat (1300) @(posedge clk);
		rd_chk(A_OSC, 32'h80);
		apb(A_PIN - 18'h4, 1'b1, 8'h5A);
		`CHK(er, 1'b1)
		rd_chk(A_PIN + 18'h1, 32'h0);
		`CHK(er, 1'b1)
		give_verdict();
	end
endmodule // cksd_top_bench
